/* inc/pin_mux_pkg.sv */
// shared constants and carrier types for the port 7 line 1/2 function select
package pin_mux_pkg;

	// =========================================================
	// register indices (byte address is four times the index)
	localparam logic [9:0] IDX_DIR = 10'h3ef;
	localparam logic [9:0] IDX_PULL = 10'h3fd;
	localparam logic [9:0] IDX_SEL = 10'h3f0;
	localparam logic [9:0] IDX_STAT = 10'h3f1;
	localparam logic [9:0] IDX_DATA = 10'h3ec;
	localparam int ADDR_W_MIN = 12;

	// =========================================================
	// field positions
	localparam int BIT_LINE1 = 1;
	localparam int BIT_LINE2 = 2;
	localparam int BIT_PULL = 6;

	// =========================================================
	// reset values
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] PULL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	// =========================================================
	// pin function codes, gray along port-in, port-out, driven uses
	typedef enum logic [2:0] {
		FN_PORT_IN = 3'h0,
		FN_PORT_OUT = 3'h1,
		FN_TIMER_OUT = 3'h3,
		FN_CLK_OUT = 3'h2,
		FN_CLK_IN = 3'h6,
		FN_MOTOR_OUT = 3'h7,
		FN_TIMER_IN = 3'h5
	} pin_fn_e;

	// selection bits gathered from the other peripherals
	typedef struct packed {
		logic i2c_mode;
		logic tb5_event;
		logic os_start6;
		logic os_start7;
		logic three_phase;
		logic serial_en;
		logic uart_async;
		logic clk_external;
		logic two_phase;
		logic ta0_gate_mode;
		logic ta1_updown_mode;
		logic ta1_pulse_mode;
	} sel_s;
	localparam sel_s SEL_RST = 12'h000;

	// =========================================================
	// bus carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;

	// peripheral signals toward and from the pins
	typedef struct packed {
		logic ta1_pulse;
		logic serial_clk;
		logic vphase;
		logic scl_out;
	} periph_out_s;

	typedef struct packed {
		logic ta1_updown;
		logic serial_clk;
		logic ta0_in;
		logic ta0_gate;
		logic tb5_in;
		logic rxd;
		logic scl_in;
	} periph_in_s;
	// receive data and i2c clock idle high, the rest low
	localparam periph_in_s IN_IDLE = 7'h03;

	// =========================================================
	// state carriers
	typedef struct packed {
		logic pin_o;
		logic pin_oe;
		logic pull_en;
		logic pin_q;
	} io_s;

	typedef struct packed {
		apb_rsp_s rsp;
		logic [7:0] dir;
		logic [7:0] pull;
		logic [7:0] data;
		sel_s sel;
		periph_in_s pin_in;
		pin_fn_e fn1;
		pin_fn_e fn2;
	} main_s;

endpackage

/* rtl/pin_io_cell.sv */
// one registered pad stage: drive, enable, pull-up and input sample
`timescale 1ns/1ns
`default_nettype none
module pin_io_cell
	import pin_mux_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// requests from the select logic
	input wire logic drive_val,
	input wire logic drive_oe,
	input wire logic pull_req,
	// pad side
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe,
	output logic pull_en,
	output logic pin_q
);

	io_s st_ff;
	io_s nxt_st;

	// pull-up is never left on while the pad drives
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pin_o = drive_val;
		nxt_st.pin_oe = drive_oe;
		nxt_st.pull_en = pull_req && !drive_oe;
		nxt_st.pin_q = pin_i;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pin_o = st_ff.pin_o;
	assign pin_oe = st_ff.pin_oe;
	assign pull_en = st_ff.pull_en;
	assign pin_q = st_ff.pin_q;

	// pull and drive exclusive, sample lags the pad by one edge
	a_pull_vs_drive: assert property (@(posedge clk) disable iff (!resetn)
		!(pull_en && pin_oe)) else $error("pull-up on while driving");
	a_sample_lag: assert property (@(posedge clk) disable iff (!resetn)
		resetn |=> pin_q == $past(pin_i)) else $error("input sample late");

endmodule
`default_nettype wire

/* rtl/port7_pin_mux.sv */
// function select for port 7 lines 1 and 2 with its apb register file
//
// Contract
// - line 2 outputs timer A1 pulse in pulse mode, not during two-phase.
// - line 2 feeds timer A1 up/down input when input and up/down mode.
// - line 2 feeds serial clock input with external clock selected.
// - line 2 drives serial clock with internal clock, direction ignored.
// - in asynchronous UART mode line 2 is plain port I/O.
// - line 2 port input gets pull-up when pull bit 6 set and pulse mode off.
// - line 1 feeds timer A0; only the gate needs mode bit 2.
// - line 1 feeds serial receive data when input without pull-up.
// - line 1 is general port; direction picks output, pull-up on input.
`timescale 1ns/1ns
`default_nettype none
module port7_pin_mux
	import pin_mux_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire apb_req_s apb_req,
	output apb_rsp_s apb_rsp,
	// peripheral side
	input wire periph_out_s pout,
	output periph_in_s pin_route,
	// port7_line1 pad
	input wire logic port7_line1_i,
	output logic port7_line1_o,
	output logic port7_line1_oe,
	output logic port7_line1_pull,
	// port7_line2 pad
	input wire logic port7_line2_i,
	output logic port7_line2_o,
	output logic port7_line2_oe,
	output logic port7_line2_pull
);

	// =========================================================
	// elaboration check
	if (ADDR_W < ADDR_W_MIN) begin : g_bad_addr
		$error("ADDR_W too small for the register map");
	end

	// =========================================================
	// decoding helpers
	function automatic logic mapped(input logic [9:0] idx);
		return idx == IDX_DIR || idx == IDX_PULL || idx == IDX_SEL ||
			idx == IDX_STAT || idx == IDX_DATA;
	endfunction

	function automatic logic ser_on(input sel_s s);
		return s.serial_en && !s.uart_async;
	endfunction

	// line 2: motor beats pulse beats serial clock beats port
	function automatic pin_fn_e line2_fn(input sel_s s, input logic dir);
		if (s.three_phase) begin
			return FN_MOTOR_OUT;
		end
		if (s.ta1_pulse_mode && !s.two_phase) begin
			return FN_TIMER_OUT;
		end
		if (ser_on(s) && !s.clk_external) begin
			return FN_CLK_OUT;
		end
		if (ser_on(s) && !dir) begin
			return FN_CLK_IN;
		end
		return dir ? FN_PORT_OUT : FN_PORT_IN;
	endfunction

	// line 1: i2c clock unless timer B5 event is selected, then timer B5 input, then port
	function automatic pin_fn_e line1_fn(input sel_s s, input logic dir,
		input logic pull);
		if (s.i2c_mode && !s.tb5_event) begin
			return s.clk_external ? FN_CLK_IN : FN_CLK_OUT;
		end
		if (s.tb5_event && !dir && !pull && !s.clk_external) begin
			return FN_TIMER_IN;
		end
		return dir ? FN_PORT_OUT : FN_PORT_IN;
	endfunction

	// =========================================================
	// state
	main_s st_ff;
	main_s nxt_st;
	logic [1:0] drv_val;
	logic [1:0] drv_oe;
	logic [1:0] pull_req;
	logic [1:0] cell_i;
	logic [1:0] cell_o;
	logic [1:0] cell_oe;
	logic [1:0] cell_pull;
	logic [1:0] cell_q;
	logic [9:0] idx;
	pin_fn_e fn1;
	pin_fn_e fn2;
	logic in1;
	logic in2;
	logic ta0_ok;

	assign idx = paddr[11:2];
	assign cell_i = {port7_line2_i, port7_line1_i};

	// =========================================================
	// pin function and routing
	always_comb begin
		fn1 = line1_fn(st_ff.sel, st_ff.dir[BIT_LINE1], st_ff.pull[BIT_PULL]);
		fn2 = line2_fn(st_ff.sel, st_ff.dir[BIT_LINE2]);
		in1 = !st_ff.dir[BIT_LINE1];
		in2 = !st_ff.dir[BIT_LINE2];
		drv_val = 2'h0;
		drv_oe = 2'h0;
		pull_req = 2'h0;
		// line 2 drive
		case (fn2)
			FN_MOTOR_OUT: begin
				drv_val[1] = pout.vphase;
				drv_oe[1] = 1'b1;
			end
			FN_TIMER_OUT: begin
				drv_val[1] = pout.ta1_pulse;
				drv_oe[1] = 1'b1;
			end
			FN_CLK_OUT: begin
				drv_val[1] = pout.serial_clk;
				drv_oe[1] = 1'b1;
			end
			FN_PORT_OUT: begin
				drv_val[1] = st_ff.data[BIT_LINE2];
				drv_oe[1] = 1'b1;
			end
			default: begin
				drv_oe[1] = 1'b0;
			end
		endcase
		pull_req[1] = (fn2 == FN_PORT_IN || fn2 == FN_CLK_IN) &&
			st_ff.pull[BIT_PULL] && !st_ff.sel.ta1_pulse_mode;
		// line 1 drive
		case (fn1)
			FN_CLK_OUT: begin
				drv_val[0] = 1'b0;
				drv_oe[0] = !pout.scl_out;
			end
			FN_PORT_OUT: begin
				drv_val[0] = st_ff.data[BIT_LINE1];
				drv_oe[0] = 1'b1;
			end
			default: begin
				drv_oe[0] = 1'b0;
			end
		endcase
		pull_req[0] = fn1 == FN_PORT_IN && st_ff.pull[BIT_PULL];
		ta0_ok = in1 && !st_ff.sel.os_start7 && !st_ff.sel.os_start6 &&
			!st_ff.sel.tb5_event && !st_ff.sel.i2c_mode;
	end

	// =========================================================
	// apb slave and routed inputs
	always_comb begin
		nxt_st = st_ff;
		nxt_st.fn1 = fn1;
		nxt_st.fn2 = fn2;
		nxt_st.pin_in = IN_IDLE;
		if (in2 && st_ff.sel.ta1_updown_mode && !st_ff.sel.ta1_pulse_mode &&
			!st_ff.sel.three_phase) begin
			nxt_st.pin_in.ta1_updown = cell_q[1];
		end
		if (fn2 == FN_CLK_IN) begin
			nxt_st.pin_in.serial_clk = cell_q[1];
		end
		nxt_st.pin_in.ta0_in = ta0_ok && cell_q[0];
		nxt_st.pin_in.ta0_gate = ta0_ok && st_ff.sel.ta0_gate_mode && cell_q[0];
		nxt_st.pin_in.tb5_in = fn1 == FN_TIMER_IN && cell_q[0];
		if (in1 && !st_ff.pull[BIT_PULL] && !st_ff.sel.tb5_event &&
			!st_ff.sel.i2c_mode && st_ff.sel.serial_en) begin
			nxt_st.pin_in.rxd = cell_q[0];
		end
		if (fn1 == FN_CLK_IN) begin
			nxt_st.pin_in.scl_in = cell_q[0];
		end
		// setup phase prepares the answer, access phase completes it
		nxt_st.rsp.pready = 1'b0;
		if (apb_req.psel && !apb_req.penable) begin
			nxt_st.rsp.pready = 1'b1;
			nxt_st.rsp.pslverr = !mapped(idx);
			case (idx)
				IDX_DIR: nxt_st.rsp.prdata = {24'h0, st_ff.dir};
				IDX_PULL: nxt_st.rsp.prdata = {24'h0, st_ff.pull};
				IDX_SEL: nxt_st.rsp.prdata = {20'h0, st_ff.sel};
				IDX_STAT: nxt_st.rsp.prdata = {24'h0, cell_q, st_ff.fn1, st_ff.fn2};
				IDX_DATA: nxt_st.rsp.prdata = {24'h0, st_ff.data[7:3], cell_q,
					st_ff.data[0]};
				default: nxt_st.rsp.prdata = 32'h0;
			endcase
		end
		// writes land only at the completing edge, low byte lane
		if (apb_req.psel && apb_req.penable && st_ff.rsp.pready &&
			apb_req.pwrite && apb_req.pstrb[0]) begin
			case (idx)
				IDX_DIR: nxt_st.dir = apb_req.pwdata[7:0];
				IDX_PULL: nxt_st.pull = apb_req.pwdata[7:0];
				IDX_DATA: nxt_st.data = apb_req.pwdata[7:0];
				default: begin
					// status is read-only; select needs byte 1 as well
				end
			endcase
			if (idx == IDX_SEL && apb_req.pstrb[1]) begin
				nxt_st.sel = apb_req.pwdata[11:0];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff.rsp <= '0;
			st_ff.dir <= DIR_RST;
			st_ff.pull <= PULL_RST;
			st_ff.data <= DATA_RST;
			st_ff.sel <= SEL_RST;
			st_ff.pin_in <= IN_IDLE;
			st_ff.fn1 <= FN_PORT_IN;
			st_ff.fn2 <= FN_PORT_IN;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// =========================================================
	// pad stages
	for (genvar g = 0; g < 2; g++) begin : g_cell
		pin_io_cell u_cell (
			.clk(clk),
			.resetn(resetn),
			.drive_val(drv_val[g]),
			.drive_oe(drv_oe[g]),
			.pull_req(pull_req[g]),
			.pin_i(cell_i[g]),
			.pin_o(cell_o[g]),
			.pin_oe(cell_oe[g]),
			.pull_en(cell_pull[g]),
			.pin_q(cell_q[g])
		);
	end

	assign apb_rsp = st_ff.rsp;
	assign pin_route = st_ff.pin_in;
	assign port7_line1_o = cell_o[0];
	assign port7_line1_oe = cell_oe[0];
	assign port7_line1_pull = cell_pull[0];
	assign port7_line2_o = cell_o[1];
	assign port7_line2_oe = cell_oe[1];
	assign port7_line2_pull = cell_pull[1];

	// =========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sel_s s;
	assign s = st_ff.sel;

	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_wr_dir;
		apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
			apb_req.pstrb[0] && idx == IDX_DIR;
	endsequence

	a_apb_one_wait: assert property (s_setup |=> apb_rsp.pready)
		else $error("no answer one edge after setup");
	a_apb_dir_write: assert property (s_wr_dir |=> st_ff.dir == $past(apb_req.pwdata[7:0]))
		else $error("direction write lost");
	a_motor_override: assert property (s.three_phase |=>
		port7_line2_oe && port7_line2_o == $past(pout.vphase)) else $error("no V phase");
	a_ta1_pulse_out: assert property (s.ta1_pulse_mode && !s.two_phase &&
		!s.three_phase |=> port7_line2_oe && port7_line2_o == $past(pout.ta1_pulse))
		else $error("pulse not on line 2");
	a_two_phase_block: assert property (s.two_phase |=> st_ff.fn2 != FN_TIMER_OUT)
		else $error("pulse during two-phase");
	a_updown_route: assert property (!st_ff.dir[BIT_LINE2] && s.ta1_updown_mode &&
		!s.ta1_pulse_mode && !s.three_phase |=> pin_route.ta1_updown == $past(cell_q[1]))
		else $error("up/down input not routed");
	a_clk_in_route: assert property (!st_ff.dir[BIT_LINE2] && ser_on(s) &&
		s.clk_external && !s.three_phase && !s.ta1_pulse_mode
		|=> pin_route.serial_clk == $past(cell_q[1])) else $error("clock input lost");
	a_clk_out_drive: assert property (ser_on(s) && !s.clk_external &&
		!s.three_phase && !s.ta1_pulse_mode
		|=> port7_line2_oe && port7_line2_o == $past(pout.serial_clk))
		else $error("serial clock not driven");
	a_uart_port: assert property (s.uart_async && !s.three_phase &&
		!s.ta1_pulse_mode |=> st_ff.fn2 inside {FN_PORT_IN, FN_PORT_OUT})
		else $error("clock on line 2 in uart mode");
	a_pull_line2: assert property (!st_ff.dir[BIT_LINE2] && st_ff.pull[BIT_PULL] &&
		!s.ta1_pulse_mode && !s.three_phase && !(ser_on(s) && !s.clk_external)
		|=> port7_line2_pull) else $error("line 2 pull-up missing");
	a_ta0_gate_route: assert property (!st_ff.dir[BIT_LINE1] && !s.os_start7 &&
		!s.os_start6 && !s.tb5_event && !s.i2c_mode
		|=> pin_route.ta0_gate == ($past(s.ta0_gate_mode) && $past(cell_q[0])))
		else $error("timer A0 gate wrong");
	a_tb5_route: assert property (!st_ff.dir[BIT_LINE1] && !st_ff.pull[BIT_PULL] &&
		s.tb5_event && !s.clk_external |=> pin_route.tb5_in == $past(cell_q[0]))
		else $error("timer B5 input lost");
	a_rxd_route: assert property (!st_ff.dir[BIT_LINE1] && !st_ff.pull[BIT_PULL] &&
		!s.tb5_event && !s.i2c_mode && s.serial_en |=> pin_route.rxd == $past(cell_q[0]))
		else $error("receive data lost");
	a_serial_off: assert property (!s.serial_en |=> pin_route.rxd &&
		!(st_ff.fn2 inside {FN_CLK_OUT, FN_CLK_IN})) else $error("serial use while off");
	a_port1_out: assert property (!s.tb5_event && !s.i2c_mode &&
		st_ff.dir[BIT_LINE1] |=> port7_line1_oe && port7_line1_o == $past(st_ff.data[1]))
		else $error("line 1 port output wrong");
	a_scl_out: assert property (s.i2c_mode && !s.tb5_event && !s.clk_external
		|=> !port7_line1_o && port7_line1_oe == !$past(pout.scl_out))
		else $error("i2c clock drive wrong");

endmodule
`default_nettype wire

/* verification/far_side.sv */
// far-side model: free-running peripheral outputs and the two pad wires
`timescale 1ns/1ns
`default_nettype none
module far_side
	import pin_mux_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// pad drive from the block, index 0 is line 1
	input wire logic [1:0] o,
	input wire logic [1:0] oe,
	input wire logic [1:0] pull,
	// outside drivers set by the bench
	input wire logic [1:0] ext_v,
	input wire logic [1:0] ext_en,
	// wire levels and peripheral outputs
	output logic [1:0] lvl,
	output periph_out_s pout,
	output periph_out_s pout_q
);
	// =========================================================
	// peripherals
	logic [3:0] cnt_ff;
	logic [1:0] lvl_ff;

	// distinct rates so a wrong source shows within eight cycles
	assign pout = '{ta1_pulse: cnt_ff[0], serial_clk: cnt_ff[1], vphase: cnt_ff[2],
		scl_out: cnt_ff[3]};

	// pout_q is what the pads show one edge later
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 4'h0;
			lvl_ff <= 2'h0;
			pout_q <= '0;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
			lvl_ff <= lvl;
			pout_q <= pout;
		end
	end

	// =========================================================
	// wire: block, then outside, then pull-up; a floating wire drifts
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (oe[i]) begin
				lvl[i] = o[i];
			end else if (ext_en[i]) begin
				lvl[i] = ext_v[i];
			end else if (pull[i]) begin
				lvl[i] = 1'b1;
			end else begin
				lvl[i] = ~lvl_ff[i];
			end
		end
	end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the port 7 line 1/2 function select
`timescale 1ns/1ns
`default_nettype none
module testbench
	import pin_mux_pkg::*;
;
	logic clk;
	logic resetn;
	logic [11:0] paddr;
	apb_req_s req;
	apb_rsp_s rsp;
	periph_in_s route;
	periph_out_s pout;
	periph_out_s pout_q;
	logic [1:0] o;
	logic [1:0] oe;
	logic [1:0] pull;
	logic [1:0] lvl;
	logic [1:0] ext_v;
	logic [1:0] ext_en;
	logic [31:0] rd;
	logic err;
	int n_errors;
	int checks_done;

	port7_pin_mux #(.ADDR_W(12)) DUT (.clk(clk), .resetn(resetn), .paddr(paddr),
		.apb_req(req), .apb_rsp(rsp), .pout(pout), .pin_route(route),
		.port7_line1_i(lvl[0]), .port7_line1_o(o[0]), .port7_line1_oe(oe[0]),
		.port7_line1_pull(pull[0]), .port7_line2_i(lvl[1]), .port7_line2_o(o[1]),
		.port7_line2_oe(oe[1]), .port7_line2_pull(pull[1]));

	far_side partner (.clk(clk), .resetn(resetn), .o(o), .oe(oe), .pull(pull),
		.ext_v(ext_v), .ext_en(ext_en), .lvl(lvl), .pout(pout), .pout_q(pout_q));

	// =========================================================
	// helpers
	task automatic complete_run();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer, then an idle cycle so the next setup never collides
	task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
		int n;
		n = 0;
		paddr <= {idx, 2'b00};
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd, pstrb: 4'hf};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		chk({31'h0, rsp.pready}, 32'h1, "apb ready");
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic settle();
		repeat (4) @(posedge clk);
	endtask

	task automatic cfg(input logic [7:0] dr, input logic [7:0] pu, input logic [11:0] s);
		apb(IDX_DIR, 1'b1, {24'h0, dr});
		apb(IDX_PULL, 1'b1, {24'h0, pu});
		apb(IDX_SEL, 1'b1, {20'h0, s});
		settle();
	endtask

	// drive a line from outside and watch one routed input
	task automatic fol(input int ln, input int k, input logic on);
		for (int v = 0; v < 2; v++) begin
			ext_en[ln] <= 1'b1;
			ext_v[ln] <= v[0];
			settle();
			chk({31'h0, route[k]}, {31'h0, on ? v[0] : IN_IDLE[k]}, "route level");
		end
	endtask

	task automatic l2(input logic [11:0] s, input logic d, input logic [2:0] fn,
		input logic oe_e, input int src);
		cfg({5'h0, d, 2'h0}, 8'h00, s);
		apb(IDX_STAT, 1'b0, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, fn}, "line2 code");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			chk({31'h0, oe[1]}, {31'h0, oe_e}, "line2 enable");
			if (src > 0) begin
				chk({31'h0, o[1]}, {31'h0, src == 1 ? pout_q.vphase :
					src == 2 ? pout_q.ta1_pulse : pout_q.serial_clk}, "line2 drive");
			end
		end
	endtask

	// =========================================================
	// scenarios
	task automatic t_regs();
		logic [9:0] idx [4] = '{IDX_DIR, IDX_PULL, IDX_DATA, IDX_SEL};
		for (int i = 0; i < 4; i++) begin
			apb(idx[i], 1'b0, 32'h0);
			chk(rd, 32'h0, "reset value");
		end
		for (int i = 0; i < 2; i++) begin
			apb(idx[i], 1'b1, 32'hffffffff);
			apb(idx[i], 1'b0, 32'h0);
			chk(rd, 32'hff, "byte register");
			apb(idx[i], 1'b1, 32'h0);
		end
		apb(10'h000, 1'b1, 32'h1);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(10'h000, 1'b0, 32'h0);
		chk(rd, 32'h0, "unmapped data");
		apb(IDX_STAT, 1'b1, 32'h3f);
		chk({31'h0, err}, 32'h0, "status write");
		apb(IDX_STAT, 1'b0, 32'h0);
		chk({26'h0, rd[5:0]}, 32'h0, "status unchanged");
	endtask

	task automatic t_port();
		// release the outside drivers so the pull-ups decide the idle level
		ext_en <= 2'b00;
		cfg(8'h06, 8'h00, 12'h000);
		apb(IDX_DATA, 1'b1, 32'h04);
		settle();
		chk({30'h0, oe}, 32'h3, "port out enable"); // direction output
		chk({30'h0, o}, 32'h2, "port out value"); // data driven
		apb(IDX_STAT, 1'b0, 32'h0);
		chk({26'h0, rd[5:0]}, 32'h09, "port out code"); // both outputs
		cfg(8'h00, 8'h40, 12'h000);
		chk({30'h0, pull}, 32'h3, "pull both"); // pulled inputs
		apb(IDX_DATA, 1'b0, 32'h0);
		chk({30'h0, rd[2:1]}, 32'h3, "pulled pads"); // input reads high
	endtask

	task automatic t_line2();
		l2(12'h0c1, 1'b0, 3'h7, 1'b1, 1); // motor output wins
		l2(12'h001, 1'b0, 3'h3, 1'b1, 2); // pulse output
		l2(12'h009, 1'b0, 3'h0, 1'b0, 0); // blocked in two-phase
		l2(12'h040, 1'b1, 3'h2, 1'b1, 3); // clock out, serial enabled first
		l2(12'h050, 1'b0, 3'h6, 1'b0, 0); // clock input code
		fol(1, 5, 1'b1); // clock reaches serial unit
		l2(12'h060, 1'b1, 3'h1, 1'b1, 0); // port in async mode
		cfg(8'h00, 8'h00, 12'h002);
		fol(1, 6, 1'b1); // up/down input
	endtask

	task automatic t_line1();
		cfg(8'h00, 8'h00, 12'h000);
		fol(0, 4, 1'b1); // count source
		fol(0, 3, 1'b0); // gate needs mode bit
		cfg(8'h00, 8'h00, 12'h004);
		fol(0, 3, 1'b1); // gate level
		cfg(8'h00, 8'h00, 12'h304);
		fol(0, 4, 1'b0); // blocked by start flags
		cfg(8'h00, 8'h00, 12'h040); // serial enabled before receive use
		fol(0, 1, 1'b1); // receive data
		cfg(8'h00, 8'h40, 12'h040);
		fol(0, 1, 1'b0); // blocked by pull-up
		cfg(8'h00, 8'h00, 12'h400);
		fol(0, 2, 1'b1); // timer B5 input
		fol(0, 4, 1'b0); // blocked by event select
		cfg(8'h00, 8'h40, 12'h400);
		fol(0, 2, 1'b0); // blocked by pull-up
		cfg(8'h00, 8'h00, 12'h810);
		fol(0, 0, 1'b1); // clock input
		cfg(8'h00, 8'h00, 12'hc00);
		fol(0, 0, 1'b0); // event select wins
		ext_en <= 2'b00;
		cfg(8'h00, 8'h00, 12'h800);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			chk({31'h0, oe[0]}, {31'h0, ~pout_q.scl_out}, "scl enable"); // clock out
			chk({31'h0, o[0]}, 32'h0, "scl low"); // open drain
		end
	endtask

	// =========================================================
	// clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// far longer than the roughly five hundred cycles the scenarios take
	initial begin
		#200000;
		n_errors++;
		complete_run();
	end

	initial begin
		resetn = 1'b0;
		paddr = 12'h000;
		req = '0;
		ext_v = 2'b00;
		// pads held low from outside, a floating pad would make data reads toggle
		ext_en = 2'b11;
		n_errors = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_port();
		t_line2();
		t_line1();
		complete_run();
	end
endmodule
`default_nettype wire
